// ==== core/rxiq_path.sv ====
/*
  Receive baseband path: input select, DC offset loop with adaptive tap
  shift, IQ imbalance correction, 0.5 dB digital gain, output FIFO.
  Assumes synchronous 12-bit twos-complement ADC samples in, and a DAC
  consumer that takes words with valid/ready.
*/
`timescale 1ns/1ps
module rxiq_path #(
  parameter int BLINK_CYC = rxiq_pkg::BLINK_HALF_CYC,
  parameter int FIFO_DEPTH = rxiq_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic signed [rxiq_pkg::ADC_W-1:0] demod_i,
  input wire logic signed [rxiq_pkg::ADC_W-1:0] demod_q,
  input wire logic signed [rxiq_pkg::ADC_W-1:0] ext_i,
  input wire logic signed [rxiq_pkg::ADC_W-1:0] ext_q,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic chan_sel,
  input wire logic dc_off_en,
  input wire logic manual_tap_en,
  input wire logic [rxiq_pkg::TAP_W-1:0] manual_tap_shift,
  input wire logic iq_corr_en,
  input wire logic iq_corr_bypass,
  input wire logic signed [rxiq_pkg::COEF_W-1:0] iq_amp_coef,
  input wire logic signed [rxiq_pkg::COEF_W-1:0] iq_phase_coef,
  input wire logic [rxiq_pkg::GAIN_W-1:0] gain_code,
  input wire logic out_data_en,
  output logic signed [rxiq_pkg::DAC_W-1:0] dac_i,
  output logic signed [rxiq_pkg::DAC_W-1:0] dac_q,
  output logic dac_valid,
  input wire logic dac_ready,
  output logic [rxiq_pkg::TAP_W-1:0] tap_shift,
  output logic offset_comp_indicator,
  output logic iq_corr_indicator
);
  import rxiq_pkg::*;

  function automatic logic signed [DAC_W-1:0] sat14(input logic signed [PROD_W-1:0] v);
    logic signed [PROD_W-1:0] hi;
    logic signed [PROD_W-1:0] lo;
    hi = PROD_W'(2 ** (DAC_W - 1) - 1);
    lo = -PROD_W'(2 ** (DAC_W - 1));
    if (v > hi) begin
      sat14 = DAC_W'(hi);
    end else if (v < lo) begin
      sat14 = DAC_W'(lo);
    end else begin
      sat14 = DAC_W'(v);
    end
  endfunction

  function automatic logic [TAP_W-1:0] clamp_tap(input logic [TAP_W-1:0] t);
    if (t < TAP_MIN) begin
      clamp_tap = TAP_MIN;
    end else if (t > TAP_MAX) begin
      clamp_tap = TAP_MAX;
    end else begin
      clamp_tap = t;
    end
  endfunction

  function automatic logic [MAG_W-1:0] mag(input logic signed [ADC_W-1:0] v);
    mag = v[ADC_W-1] ? MAG_W'(-MAG_W'(v)) : MAG_W'(v);
  endfunction

  function automatic logic [TAP_W-1:0] lead_pos(input logic [MAG_W-1:0] v);
    lead_pos = '0;
    for (int b = 0; b < MAG_W; b++) begin
      if (v[b]) begin
        lead_pos = TAP_W'(b);
      end
    end
  endfunction

  // 0.5 dB steps within one octave, Q15 with 1.0 = 16384 << 1
  function automatic logic [MANT_W-1:0] mant(input logic [3:0] f);
    unique case (f)
      4'h0: mant = 16'h4000;
      4'h1: mant = 16'h43cb;
      4'h2: mant = 16'h47cf;
      4'h3: mant = 16'h4c10;
      4'h4: mant = 16'h5092;
      4'h5: mant = 16'h5558;
      4'h6: mant = 16'h5a67;
      4'h7: mant = 16'h5fc2;
      4'h8: mant = 16'h656f;
      4'h9: mant = 16'h6b71;
      4'ha: mant = 16'h71cf;
      4'hb: mant = 16'h788e;
      default: mant = 16'h4000;
    endcase
  endfunction

  // Stall term: the FIFO back-pressure holds the whole pipeline
  logic adv;
  logic fifo_in_ready;
  assign adv = fifo_in_ready || !out_data_en;
  assign in_ready = adv;

  // Stage 0: input select
  logic v0, next_v0;
  logic signed [ADC_W-1:0] i0, q0, next_i0, next_q0;

  always_comb begin
    next_v0 = v0;
    next_i0 = i0;
    next_q0 = q0;
    if (adv) begin
      next_v0 = in_valid;
      next_i0 = chan_sel ? ext_i : demod_i;
      next_q0 = chan_sel ? ext_q : demod_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      v0 <= 1'b0;
      i0 <= '0;
      q0 <= '0;
    end else begin
      v0 <= next_v0;
      i0 <= next_i0;
      q0 <= next_q0;
    end
  end

  // Power estimate and tap selection
  logic [PWR_W-1:0] pwr, next_pwr;
  logic [SETTLE_W-1:0] settle, next_settle;
  logic [TAP_W-1:0] next_tap, auto_tap;
  logic [MAG_W-1:0] pwr_avg;

  assign pwr_avg = MAG_W'(pwr >> PWR_SHIFT);

  always_comb begin
    next_pwr = pwr;
    next_settle = settle;
    if (v0 && adv) begin
      next_pwr = pwr - (pwr >> PWR_SHIFT) + PWR_W'(mag(i0)) + PWR_W'(mag(q0));
      if (settle != SETTLE_N) begin
        next_settle = settle + 1'b1;
      end
    end
    // Louder input gets a longer tap so the loop does not chase the signal
    if (settle != SETTLE_N) begin
      auto_tap = TAP_INIT;
    end else begin
      auto_tap = clamp_tap(lead_pos(pwr_avg) + TAP_LEAD_OFS);
    end
    next_tap = manual_tap_en ? clamp_tap(manual_tap_shift) : auto_tap;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pwr <= '0;
      settle <= '0;
      tap_shift <= TAP_INIT;
    end else begin
      pwr <= next_pwr;
      settle <= next_settle;
      tap_shift <= next_tap;
    end
  end

  // Stage 1: DC offset loop, integrator of its own output
  logic v1, next_v1;
  logic signed [ACC_W-1:0] acc_i, acc_q, next_acc_i, next_acc_q;
  logic signed [DAC_W-1:0] i1, q1, next_i1, next_q1;
  logic signed [DAC_W-1:0] dif_i, dif_q;

  always_comb begin
    dif_i = DAC_W'(i0) - DAC_W'(acc_i >>> tap_shift);
    dif_q = DAC_W'(q0) - DAC_W'(acc_q >>> tap_shift);
    next_v1 = v1;
    next_i1 = i1;
    next_q1 = q1;
    next_acc_i = acc_i;
    next_acc_q = acc_q;
    if (adv) begin
      next_v1 = v0;
      // Estimate is kept while disabled so re-enabling does not re-settle
      next_i1 = dc_off_en ? dif_i : DAC_W'(i0);
      next_q1 = dc_off_en ? dif_q : DAC_W'(q0);
      if (v0 && dc_off_en) begin
        next_acc_i = acc_i + ACC_W'(dif_i);
        next_acc_q = acc_q + ACC_W'(dif_q);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      v1 <= 1'b0;
      i1 <= '0;
      q1 <= '0;
      acc_i <= '0;
      acc_q <= '0;
    end else begin
      v1 <= next_v1;
      i1 <= next_i1;
      q1 <= next_q1;
      acc_i <= next_acc_i;
      acc_q <= next_acc_q;
    end
  end

  // Stage 2: IQ imbalance correction on the Q rail
  logic v2, next_v2;
  logic iq_active;
  logic signed [DAC_W-1:0] i2, q2, next_i2, next_q2;
  logic signed [PROD_W-1:0] iq_prod;

  assign iq_active = iq_corr_en && !iq_corr_bypass;

  always_comb begin
    iq_prod = PROD_W'(q1) * PROD_W'(iq_amp_coef) + PROD_W'(i1) * PROD_W'(iq_phase_coef);
    next_v2 = v2;
    next_i2 = i2;
    next_q2 = q2;
    if (adv) begin
      next_v2 = v1;
      next_i2 = i1;
      next_q2 = iq_active ? sat14(PROD_W'(q1) + (iq_prod >>> COEF_FRAC)) : q1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      v2 <= 1'b0;
      i2 <= '0;
      q2 <= '0;
    end else begin
      v2 <= next_v2;
      i2 <= next_i2;
      q2 <= next_q2;
    end
  end

  // Stage 3: gain, unity sample weight so 12 dB fills the 14-bit range
  logic [GAIN_W-1:0] code_c, gain_k;
  logic [2:0] gain_oct;
  logic [3:0] gain_frac;
  logic signed [PROD_W-1:0] gmul, g_i, g_q;
  logic signed [DAC_W-1:0] o_i, o_q;

  always_comb begin
    code_c = (gain_code > GAIN_CODE_MAX) ? GAIN_CODE_MAX : gain_code;
    // Octave split keeps the table at 12 entries; 6.02 vs 6 dB per octave
    gain_k = code_c + GAIN_K_OFS;
    gain_oct = 3'(gain_k / GAIN_STEPS_OCT);
    gain_frac = 4'(gain_k % GAIN_STEPS_OCT);
    gmul = PROD_W'(mant(gain_frac)) <<< gain_oct;
    g_i = (PROD_W'(i2) * gmul) >>> MANT_FRAC;
    g_q = (PROD_W'(q2) * gmul) >>> MANT_FRAC;
    o_i = sat14(g_i);
    o_q = sat14(g_q);
  end

  // Output FIFO; disabled output drops samples instead of stalling
  logic fifo_out_valid;
  logic [2*DAC_W-1:0] fifo_out;

  rxiq_fifo #(
    .WIDTH(2 * DAC_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_data({o_i, o_q}),
    .in_valid(v2 && out_data_en),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(dac_ready)
  );

  assign dac_i = fifo_out[2*DAC_W-1:DAC_W];
  assign dac_q = fifo_out[DAC_W-1:0];
  assign dac_valid = fifo_out_valid;

  // Indicator blink timebase
  logic [31:0] blink_cnt, next_blink_cnt;
  logic blink, next_blink;
  logic next_offset_comp_indicator, next_iq_corr_indicator;

  always_comb begin
    next_blink_cnt = blink_cnt + 32'h1;
    next_blink = blink;
    if (blink_cnt >= 32'(BLINK_CYC - 1)) begin
      next_blink_cnt = '0;
      next_blink = !blink;
    end
    next_offset_comp_indicator = dc_off_en && next_blink;
    next_iq_corr_indicator = iq_active && next_blink;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      blink_cnt <= '0;
      blink <= 1'b0;
      offset_comp_indicator <= 1'b0;
      iq_corr_indicator <= 1'b0;
    end else begin
      blink_cnt <= next_blink_cnt;
      blink <= next_blink;
      offset_comp_indicator <= next_offset_comp_indicator;
      iq_corr_indicator <= next_iq_corr_indicator;
    end
  end
endmodule

// ==== core/rxiq_pkg.sv ====
/*
  Shared constants for the receive baseband correction path: sample widths,
  offset-loop tap limits, gain table layout, indicator timing, FIFO depth.
  Assumes a single 40 MHz clock domain and twos-complement samples.
*/
package rxiq_pkg;
  localparam int ADC_W = 12;
  localparam int DAC_W = 14;
  localparam int COEF_W = 12;
  localparam int COEF_FRAC = 11;
  localparam int TAP_W = 5;
  localparam logic [TAP_W-1:0] TAP_INIT = 5'h0d;
  localparam logic [TAP_W-1:0] TAP_MIN = 5'h0a;
  localparam logic [TAP_W-1:0] TAP_MAX = 5'h12;
  localparam logic [TAP_W-1:0] TAP_LEAD_OFS = 5'h06;
  localparam int ACC_W = ADC_W + 20;
  localparam int MAG_W = ADC_W + 1;
  localparam int PWR_SHIFT = 4;
  localparam int PWR_W = MAG_W + PWR_SHIFT;
  localparam int SETTLE_W = 5;
  localparam logic [SETTLE_W-1:0] SETTLE_N = 5'h10;
  localparam int GAIN_W = 6;
  localparam logic [GAIN_W-1:0] GAIN_CODE_MAX = 6'h2a;
  localparam logic [GAIN_W-1:0] GAIN_CODE_RST = 6'h1d;
  localparam logic [GAIN_W-1:0] GAIN_K_OFS = 6'h06;
  localparam logic [GAIN_W-1:0] GAIN_STEPS_OCT = 6'h0c;
  localparam int MANT_W = 16;
  localparam int MANT_FRAC = 15;
  localparam int PROD_W = 36;
  localparam int CLK_KHZ = 40000;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
  localparam int FIFO_DEPTH = 8;
endpackage

// ==== core/rxiq_fifo.sv ====
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module rxiq_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  // Honest full: ready drops only when every slot holds data
  assign in_ready = (count != FULL);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    mem <= next_mem;
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end
endmodule

// ==== tb/rxiq_path_properties.sv ====
/*
  Port-level checker for the receive path, bound into rxiq_path.
  Assumes one clock, synchronous srst, and BLINK_CYC set to 8 in the bench.
*/
`timescale 1ns/1ps
module rxiq_path_properties #(
  parameter int BLINK_CYC = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_ready,
  input wire logic dc_off_en,
  input wire logic manual_tap_en,
  input wire logic [rxiq_pkg::TAP_W-1:0] manual_tap_shift,
  input wire logic iq_corr_en,
  input wire logic iq_corr_bypass,
  input wire logic out_data_en,
  input wire logic signed [rxiq_pkg::DAC_W-1:0] dac_i,
  input wire logic signed [rxiq_pkg::DAC_W-1:0] dac_q,
  input wire logic dac_valid,
  input wire logic dac_ready,
  input wire logic [rxiq_pkg::TAP_W-1:0] tap_shift,
  input wire logic offset_comp_indicator,
  input wire logic iq_corr_indicator
);
  import rxiq_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Length of the current lit phase of the offset indicator
  logic [31:0] dc_on_run;
  always_ff @(posedge clk) begin
    if (srst || !offset_comp_indicator) begin
      dc_on_run <= '0;
    end else begin
      dc_on_run <= dc_on_run + 32'h1;
    end
  end
  // Blink figures below hold only for BLINK_CYC of 8
  // Enable already on two cycles earlier, so the rise is a phase start, not a late enable
  sequence s_blink_on;
    ($rose(offset_comp_indicator) && $past(dc_off_en, 2)) ##1 dc_off_en [*4];
  endsequence
  a_blink_bound: assert property (dc_on_run <= 32'(BLINK_CYC))
    else $error("offset indicator lit beyond half period");
  a_reset_state: assert property ($fell(srst) |-> tap_shift == TAP_INIT && !dac_valid)
    else $error("state after reset wrong");
  a_tap_range: assert property (tap_shift >= TAP_MIN && tap_shift <= TAP_MAX)
    else $error("tap shift out of range");
  a_manual_tap: assert property (manual_tap_en
    && manual_tap_shift inside {[TAP_MIN:TAP_MAX]} |=> tap_shift == $past(manual_tap_shift))
    else $error("manual tap ignored");
  a_dc_ind_off: assert property (!dc_off_en |=> !offset_comp_indicator)
    else $error("offset indicator lit while off");
  a_iq_ind_off: assert property (!iq_corr_en || iq_corr_bypass |=> !iq_corr_indicator)
    else $error("iq indicator lit while off");
  a_blink_hold: assert property (s_blink_on |-> offset_comp_indicator)
    else $error("blink phase too short");
  a_blink_toggle: assert property (offset_comp_indicator [*8] |=> !offset_comp_indicator)
    else $error("blink phase too long");
  a_disabled_quiet: assert property (!out_data_en && !dac_valid |=> !dac_valid)
    else $error("word forwarded while output off");
  a_ready_drop: assert property (!out_data_en |-> in_ready)
    else $error("input held off while output off");
  a_refuse_full: assert property (!in_ready |-> dac_valid)
    else $error("refused with empty fifo");
  a_head_hold: assert property (dac_valid && !dac_ready |=> dac_valid
    && $stable(dac_i) && $stable(dac_q)) else $error("head word changed while stalled");
endmodule
bind rxiq_path rxiq_path_properties #(.BLINK_CYC(BLINK_CYC)) u_props (.clk(clk), .srst(srst),
  .in_ready(in_ready), .dc_off_en(dc_off_en), .manual_tap_en(manual_tap_en),
  .manual_tap_shift(manual_tap_shift), .iq_corr_en(iq_corr_en), .iq_corr_bypass(iq_corr_bypass),
  .out_data_en(out_data_en), .dac_i(dac_i), .dac_q(dac_q), .dac_valid(dac_valid),
  .dac_ready(dac_ready), .tap_shift(tap_shift), .offset_comp_indicator(offset_comp_indicator),
  .iq_corr_indicator(iq_corr_indicator));

// ==== tb/rxiq_dac_sink.sv ====
/*
  Output converter stand-in: takes words with valid/ready, can stall.
  Assumes the bench moves stall just after a rising edge.
*/
`timescale 1ns/1ps
module rxiq_dac_sink (
  input wire logic clk,
  input wire logic signed [rxiq_pkg::DAC_W-1:0] dac_i,
  input wire logic signed [rxiq_pkg::DAC_W-1:0] dac_q,
  input wire logic dac_valid,
  input wire logic stall,
  output logic dac_ready
);
  import rxiq_pkg::*;
  logic [2*DAC_W-1:0] got [$];
  assign dac_ready = !stall;
  // Only a word offered as valid counts as forwarded
  always @(posedge clk) begin
    if (dac_valid === 1'b1 && dac_ready) got.push_back({dac_i, dac_q});
  end
endmodule

// ==== tb/test_rxiq_path.sv ====
/*
  Self-checking bench for rxiq_path with a stalling converter sink.
  Assumes the package constants and a short blink count of 8.
*/
`timescale 1ns/1ps
module test_rxiq_path;
  import rxiq_pkg::*;
  logic clk = 0, srst = 1, in_valid = 0, chan_sel = 0, dc_off_en = 0, manual_tap_en = 0;
  logic iq_corr_en = 0, iq_corr_bypass = 1, out_data_en = 1, stall = 0, refused = 0;
  logic in_ready, dac_valid, dac_ready, offset_comp_indicator, iq_corr_indicator;
  logic signed [ADC_W-1:0] demod_i = 0, demod_q = 0, ext_i = 0, ext_q = 0;
  logic signed [COEF_W-1:0] iq_amp_coef = 0, iq_phase_coef = 0;
  logic [TAP_W-1:0] manual_tap_shift = 0, tap_shift;
  logic [GAIN_W-1:0] gain_code = 6'h1d;
  logic signed [DAC_W-1:0] dac_i, dac_q;
  int miscompares = 0, check_count = 0, acc_i = 0, acc_q = 0;
  rxiq_path #(.BLINK_CYC(8)) dut (.clk, .srst, .demod_i, .demod_q, .ext_i, .ext_q, .in_valid,
    .in_ready, .chan_sel, .dc_off_en, .manual_tap_en, .manual_tap_shift, .iq_corr_en,
    .iq_corr_bypass, .iq_amp_coef, .iq_phase_coef, .gain_code, .out_data_en, .dac_i, .dac_q,
    .dac_valid, .dac_ready, .tap_shift, .offset_comp_indicator, .iq_corr_indicator);
  rxiq_dac_sink sink (.clk, .dac_i, .dac_q, .dac_valid, .stall, .dac_ready);
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic close_out;
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [15:0] gi(int k);
    return 16'($signed(sink.got[k][2*DAC_W-1:DAC_W]));
  endfunction
  function automatic logic [15:0] gq(int k);
    return 16'($signed(sink.got[k][DAC_W-1:0]));
  endfunction
  // Ext pair is the demod pair swapped, so the selected source shows
  task automatic send(input int a, input int b);
    demod_i = ADC_W'(a);
    demod_q = ADC_W'(b);
    ext_i = ADC_W'(b);
    ext_q = ADC_W'(a);
    in_valid = 1;
    while (in_ready !== 1'b1) begin
      refused = 1;
      @(posedge clk);
      #2;
    end
    @(posedge clk);
    #2;
  endtask
  task automatic drain(input int n);
    int k;
    k = 0;
    in_valid = 0;
    while (sink.got.size() < n && k < 200) begin
      @(posedge clk);
      #2;
      k++;
    end
    chk("words", 16'(n), 16'(sink.got.size()));
  endtask
  task automatic run1(input int a, input int b, input int ei, input int eq);
    sink.got.delete();
    send(a, b);
    drain(1);
    chk("dac_i", 16'(ei), gi(0));
    chk("dac_q", 16'(eq), gq(0));
  endtask
  task automatic t_dc;
    int ei, eq;
    dc_off_en = 1;
    gain_code = 6'h06;
    chk("tap_init", 16'(TAP_INIT), 16'(tap_shift));
    sink.got.delete();
    for (int k = 0; k < 12; k++) send(1800, -1800);
    drain(12);
    for (int k = 0; k < 12; k++) begin
      ei = 1800 - (acc_i >>> 13);
      eq = -1800 - (acc_q >>> 13);
      acc_i += ei;
      acc_q += eq;
      chk("dc_i", 16'(ei), gi(k));
      chk("dc_q", 16'(eq), gq(k));
    end
    dc_off_en = 0;
    run1(700, -300, 700, -300);
  endtask
  task automatic t_path;
    iq_phase_coef = 12'h400;
    iq_corr_en = 1;
    iq_corr_bypass = 0;
    run1(400, 100, 400, 300);
    iq_amp_coef = 12'h400;
    iq_phase_coef = 12'h000;
    run1(400, 100, 400, 150);
    iq_corr_bypass = 1;
    run1(400, 100, 400, 100);
    iq_corr_bypass = 0;
    iq_corr_en = 0;
    run1(400, 100, 400, 100);
    chan_sel = 1;
    run1(400, 100, 100, 400);
    chan_sel = 0;
  endtask
  task automatic t_gain;
    logic [GAIN_W-1:0] codes [5] = '{6'h06, 6'h12, 6'h1e, 6'h2a, 6'h32};
    int mul [5] = '{1, 2, 4, 8, 8};
    for (int k = 0; k < 5; k++) begin
      gain_code = codes[k];
      run1(500, -250, 500 * mul[k], -250 * mul[k]);
    end
    run1(1500, -1500, 8191, -8192);
    // Recommended 11.5 dB is about x3.77: full scale lands near 7711, short of the rail
    gain_code = GAIN_CODE_RST;
    sink.got.delete();
    send(2047, -2048);
    drain(1);
    chk("rec_i_unsat", 16'h0001, 16'(gi(0) > 16'h1d00 && gi(0) < 16'h1fff));
    chk("rec_q_unsat", 16'h0001, 16'($signed(gq(0)) > -16'sd8192 && $signed(gq(0)) < -16'sd7424));
  endtask
  task automatic t_tap;
    logic [TAP_W-1:0] low_tap;
    logic [TAP_W-1:0] req [3] = '{5'h1f, 5'h03, 5'h0f};
    logic [TAP_W-1:0] exp_tap [3] = '{TAP_MAX, TAP_MIN, 5'h0f};
    sink.got.delete();
    out_data_en = 0;
    manual_tap_en = 1;
    for (int k = 0; k < 3; k++) begin
      manual_tap_shift = req[k];
      @(posedge clk);
      #2;
      chk("tap_manual", 16'(exp_tap[k]), 16'(tap_shift));
    end
    manual_tap_en = 0;
    repeat (300) send(0, 0);
    low_tap = tap_shift;
    repeat (300) send(2000, -2000);
    in_valid = 0;
    repeat (6) @(posedge clk);
    #2;
    chk("tap_auto", 16'h0001, 16'(tap_shift > low_tap));
    chk("dropped", 16'h0000, 16'(sink.got.size()));
    out_data_en = 1;
  endtask
  // Sink stalls long enough for the fifo and pipeline to fill and refuse
  task automatic t_fifo;
    gain_code = 6'h06;
    sink.got.delete();
    stall = 1;
    refused = 0;
    fork
      for (int k = 0; k < 12; k++) send(k * 10, -k);
      begin
        repeat (40) @(posedge clk);
        #2;
        stall = 0;
      end
    join
    drain(12);
    chk("refused", 16'h0001, 16'(refused));
    for (int k = 0; k < 12; k++) begin
      chk("fifo_i", 16'(k * 10), gi(k));
      chk("fifo_q", 16'(-k), gq(k));
    end
  endtask
  task automatic t_blink;
    int r1, r2;
    for (int pass = 0; pass < 2; pass++) begin
      r1 = 0;
      r2 = 0;
      dc_off_en = (pass == 0);
      iq_corr_en = 1;
      iq_corr_bypass = (pass == 1);
      repeat (40) begin
        @(posedge clk);
        #2;
        r1 += int'(offset_comp_indicator === 1'b1);
        r2 += int'(iq_corr_indicator === 1'b1);
      end
      chk("dc_blink", 16'(pass == 0), 16'(r1 > 8 && r1 < 32));
      chk("iq_blink", 16'(pass == 0), 16'(r2 > 8 && r2 < 32));
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #2;
    srst = 0;
    t_dc();
    t_path();
    t_gain();
    t_tap();
    t_fifo();
    t_blink();
    close_out();
  end
  // Tests need under a thousand cycles, so this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end
endmodule
